// >>> apc_consts.svh
// Constants for the attribute palette controller: port addresses, indices, fields and resets.
`ifndef APC_CONSTS_SVH
`define APC_CONSTS_SVH
`define APC_PORT_WRITE      16'h03C0
`define APC_PORT_READ       16'h03C1
`define APC_PORT_STAT_MONO  16'h03BA
`define APC_PORT_STAT_COLOR 16'h03DA
`define APC_IDX_PAL_LAST    5'h0F
`define APC_IDX_MODE        5'h10
`define APC_IDX_OVERSCAN    5'h11
`define APC_IDX_PLANE       5'h12
`define APC_IDX_PAN         5'h13
`define APC_IDX_CSEL        5'h14
`define APC_IDX_MASK        8'h3F
`define APC_PAL_MASK        8'h3F
`define APC_MODE_MASK       8'hEF
`define APC_PLANE_MASK      8'h3F
`define APC_NIB_MASK        8'h0F
`define APC_SRC_BIT         5
`define APC_MB_UPPER_SEL    7
`define APC_MB_PIX8         6
`define APC_MB_SPLIT_PAN    5
`define APC_MB_BLINK        3
`define APC_MB_LINE_GFX     2
`define APC_MB_MONO         1
`define APC_MB_GFX          0
`define APC_RST_BYTE        8'h00
`define APC_LGFX_LO         8'hC0
`define APC_LGFX_HI         8'hDF
`endif

// >>> apc_pkg.sv
// Types shared by the attribute palette controller modules.
package apc_pkg;
   typedef logic [5:0] apc_pal_t;
   typedef enum logic [0:0] {
      APC_SEL_INDEX = 1'b0,
      APC_SEL_DATA  = 1'b1
   } apc_sel_t;
   typedef enum logic [0:0] {
      APC_PAN_NORMAL = 1'b0,
      APC_PAN_FORCED = 1'b1
   } apc_pan_t;
endpackage : apc_pkg

// >>> apc_pal_if.sv
// Interface carrying palette write and lookup signals between the controller and the palette.
`timescale 1ns/1ns
interface apc_pal_if;
   import apc_pkg::*;
   logic       wr_en;
   logic [3:0] wr_idx;
   apc_pal_t   wr_data;
   logic [3:0] rd_idx;
   apc_pal_t   rd_data;
   logic [3:0] lk_idx;
   apc_pal_t   lk_data;
   modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx, output lk_idx,
                 input rd_data, input lk_data);
   modport pal  (input wr_en, input wr_idx, input wr_data, input rd_idx, input lk_idx,
                 output rd_data, output lk_data);
endinterface : apc_pal_if

// >>> apc_palette.sv
// Sixteen-entry palette store with one host port and one display lookup port.
`timescale 1ns/1ns
`include "apc_consts.svh"
module apc_palette
   import apc_pkg::*;
#(
   parameter int ENTRIES = 16
) (
   input  wire logic clk,
   input  wire logic rst,
   apc_pal_if.pal    p
);
   apc_pal_t mem_r [ENTRIES];

   // Each entry keeps six bits; the host reads it through rd_idx.
   genvar g;
   for (g = 0; g < ENTRIES; g++) begin : g_ent
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            mem_r[g] <= '0;
         end else if (p.wr_en && p.wr_idx == 4'(g)) begin
            mem_r[g] <= p.wr_data;
         end
      end
   end

   assign p.rd_data = mem_r[p.rd_idx];
   assign p.lk_data = mem_r[p.lk_idx];
endmodule : apc_palette

// >>> apc_attr_ctrl.sv
// Attribute palette controller: indexed host registers, palette lookup and colour output path.
// Notes on behaviour
// - Status port read clears index/data selector.
// - Each attribute write toggles selector; index then data.
// - Data port read returns indexed register, no toggle.
// - Index register: bits 4-0 index, bit 5 source.
// - Source bit 1 lets video data drive palette.
// - Indices 00-0F are six-bit palette entries.
// - Pixel value selects entry sent to colour converter.
// - Index 10 is mode control; bit 4 reserved.
// - Mode bit 7 takes colour bits 5,4 from select.
// - Mode bit 6 enables 8-bit pixel path.
// - Mode bit 5: line compare zeroes panning until vsync.
// - Mode bit 3 blink, else background intensity.
// - Mode bit 2: ninth dot copies eighth, C0-DF.
// - Mode bit 1 selects monochrome emulation.
// - Mode bit 0 selects graphics attribute processing.
// - Colour select bits 1,0 replace palette bits 5,4.
`timescale 1ns/1ns
`include "apc_consts.svh"
module apc_attr_ctrl
   import apc_pkg::*;
(
   // Clock and reset.
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   // Host I/O port access.
   input  wire logic [15:0] IO_ADDR,
   input  wire logic        IO_WR,
   input  wire logic        IO_RD,
   input  wire logic [7:0]  IO_WDATA,
   output logic      [7:0]  IO_RDATA,
   // Pixel pipeline inputs.
   input  wire logic [7:0]  PIX_ATTR,
   input  wire logic        PIX_BLINK_PHASE,
   input  wire logic        LINE_CMP_MATCH,
   input  wire logic        VSYNC,
   // Colour converter and display option outputs.
   output logic      [7:0]  COLOR_OUT,
   output logic      [3:0]  PAN_OUT,
   output logic      [3:0]  PLANE_ENABLE,
   output logic      [7:0]  OVERSCAN_COLOR,
   output logic             PIXEL_WIDTH_8BIT,
   output logic             MONO_EMULATION,
   output logic             GRAPHICS_MODE,
   output logic             LINE_GFX_ENABLE,
   output logic             BLINK_ENABLE,
   output logic             PALETTE_SOURCE_VIDEO
);
   apc_pal_if pal_bus ();

   apc_sel_t   sel_r;
   logic [5:0] index_r;
   logic [7:0] mode_r;
   logic [7:0] overscan_r;
   logic [7:0] plane_r;
   logic [7:0] pan_r;
   logic [7:0] csel_r;
   apc_pan_t   pan_state_r;
   logic       lcm_s1_r;
   logic       lcm_s2_r;
   logic       vs_s1_r;
   logic       vs_s2_r;
   logic [7:0] rdata_nxt;
   logic       wr_port;
   logic       rd_port;
   logic       rd_stat;
   logic       data_wr;
   logic [4:0] idx;

   // Reports whether an index addresses one of the sixteen palette entries.
   function automatic logic is_pal(input logic [4:0] i);
      return i <= `APC_IDX_PAL_LAST;
   endfunction : is_pal

   assign wr_port = IO_WR && IO_ADDR == `APC_PORT_WRITE;
   assign rd_port = IO_RD && IO_ADDR == `APC_PORT_READ;
   assign rd_stat = IO_RD && (IO_ADDR == `APC_PORT_STAT_MONO ||
                              IO_ADDR == `APC_PORT_STAT_COLOR);
   assign data_wr = wr_port && sel_r == APC_SEL_DATA;
   assign idx     = index_r[4:0];

   // A status read wins over a simultaneous write so software always resynchronises.
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         sel_r <= APC_SEL_INDEX;
      end else if (rd_stat) begin
         sel_r <= APC_SEL_INDEX;
      end else if (wr_port) begin
         sel_r <= (sel_r == APC_SEL_INDEX) ? APC_SEL_DATA : APC_SEL_INDEX;
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         index_r <= '0;
      end else if (wr_port && sel_r == APC_SEL_INDEX) begin
         index_r <= 6'(IO_WDATA & `APC_IDX_MASK);
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         mode_r     <= `APC_RST_BYTE;
         overscan_r <= `APC_RST_BYTE;
         plane_r    <= `APC_RST_BYTE;
         pan_r      <= `APC_RST_BYTE;
         csel_r     <= `APC_RST_BYTE;
      end else if (data_wr) begin
         unique case (idx)
            `APC_IDX_MODE:     mode_r     <= IO_WDATA & `APC_MODE_MASK;
            `APC_IDX_OVERSCAN: overscan_r <= IO_WDATA;
            `APC_IDX_PLANE:    plane_r    <= IO_WDATA & `APC_PLANE_MASK;
            `APC_IDX_PAN:      pan_r      <= IO_WDATA & `APC_NIB_MASK;
            `APC_IDX_CSEL:     csel_r     <= IO_WDATA & `APC_NIB_MASK;
            default: ;
         endcase
      end
   end

   // Palette writes are taken only while the source bit is clear.
   assign pal_bus.wr_en   = data_wr && is_pal(idx) && !index_r[`APC_SRC_BIT];
   assign pal_bus.wr_idx  = idx[3:0];
   assign pal_bus.wr_data = IO_WDATA[5:0];
   assign pal_bus.rd_idx  = idx[3:0];

   always_comb begin
      rdata_nxt = `APC_RST_BYTE;
      if (sel_r == APC_SEL_INDEX && !rd_port) begin
         rdata_nxt = `APC_RST_BYTE;
      end else if (is_pal(idx)) begin
         rdata_nxt = {2'b00, pal_bus.rd_data};
      end else begin
         unique case (idx)
            `APC_IDX_MODE:     rdata_nxt = mode_r;
            `APC_IDX_OVERSCAN: rdata_nxt = overscan_r;
            `APC_IDX_PLANE:    rdata_nxt = plane_r;
            `APC_IDX_PAN:      rdata_nxt = pan_r;
            `APC_IDX_CSEL:     rdata_nxt = csel_r;
            default:           rdata_nxt = `APC_RST_BYTE;
         endcase
      end
   end

   // Read data is registered; the selector is not touched by this read.
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         IO_RDATA <= `APC_RST_BYTE;
      end else if (rd_port) begin
         IO_RDATA <= rdata_nxt;
      end
   end

   apc_palette #(
      .ENTRIES (16)
   ) u_palette (
      .clk (CLK),
      .rst (SYS_RST),
      .p   (pal_bus.pal)
   );

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         lcm_s1_r <= 1'b0;
         lcm_s2_r <= 1'b0;
         vs_s1_r  <= 1'b0;
         vs_s2_r  <= 1'b0;
      end else begin
         lcm_s1_r <= LINE_CMP_MATCH;
         lcm_s2_r <= lcm_s1_r;
         vs_s1_r  <= VSYNC;
         vs_s2_r  <= vs_s1_r;
      end
   end

   // Panning is held at zero from a line compare match until vertical sync.
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pan_state_r <= APC_PAN_NORMAL;
      end else begin
         unique case (pan_state_r)
            APC_PAN_NORMAL: begin
               if (lcm_s2_r && !vs_s2_r && mode_r[`APC_MB_SPLIT_PAN]) begin
                  pan_state_r <= APC_PAN_FORCED;
               end
            end
            APC_PAN_FORCED: begin
               if (vs_s2_r || !mode_r[`APC_MB_SPLIT_PAN]) begin
                  pan_state_r <= APC_PAN_NORMAL;
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         PAN_OUT <= '0;
      end else begin
         PAN_OUT <= (pan_state_r == APC_PAN_FORCED) ? 4'h0 : pan_r[3:0];
      end
   end

   // Attribute bit 7 is blink with blink enabled outside 8-bit pixel mode, else intensity.
   logic [7:0] attr_eff;
   logic       blink_bit;
   always_comb begin
      attr_eff  = PIX_ATTR;
      blink_bit = mode_r[`APC_MB_BLINK] && !mode_r[`APC_MB_PIX8];
      if (blink_bit && PIX_ATTR[7]) begin
         attr_eff[7] = 1'b0;
         if (PIX_BLINK_PHASE) begin
            attr_eff[3:0] = PIX_ATTR[7:4] & 4'h7;
         end
      end
   end

   // The palette lookup is driven from video data only while the source bit is set.
   assign pal_bus.lk_idx = index_r[`APC_SRC_BIT] ? (attr_eff[3:0] & plane_r[3:0]) : 4'h0;

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         COLOR_OUT <= `APC_RST_BYTE;
      end else if (mode_r[`APC_MB_PIX8]) begin
         COLOR_OUT <= PIX_ATTR;
      end else if (mode_r[`APC_MB_UPPER_SEL]) begin
         COLOR_OUT <= {csel_r[3:2], csel_r[1:0], pal_bus.lk_data[3:0]};
      end else begin
         COLOR_OUT <= {csel_r[3:2], pal_bus.lk_data};
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         PLANE_ENABLE         <= '0;
         OVERSCAN_COLOR       <= `APC_RST_BYTE;
         PIXEL_WIDTH_8BIT     <= 1'b0;
         MONO_EMULATION       <= 1'b0;
         GRAPHICS_MODE        <= 1'b0;
         LINE_GFX_ENABLE      <= 1'b0;
         BLINK_ENABLE         <= 1'b0;
         PALETTE_SOURCE_VIDEO <= 1'b0;
      end else begin
         PLANE_ENABLE         <= plane_r[3:0];
         OVERSCAN_COLOR       <= overscan_r;
         PIXEL_WIDTH_8BIT     <= mode_r[`APC_MB_PIX8];
         MONO_EMULATION       <= mode_r[`APC_MB_MONO];
         GRAPHICS_MODE        <= mode_r[`APC_MB_GFX];
         LINE_GFX_ENABLE      <= mode_r[`APC_MB_LINE_GFX];
         BLINK_ENABLE         <= mode_r[`APC_MB_BLINK];
         PALETTE_SOURCE_VIDEO <= index_r[`APC_SRC_BIT];
      end
   end
endmodule : apc_attr_ctrl

// >>> apc_attr_ctrl_assertions.sv
// Port-level assertions for the attribute palette controller.
`timescale 1ns/1ns
module apc_attr_ctrl_checker (
   // Clock and reset.
   input wire logic        CLK,
   input wire logic        SYS_RST,
   // Host port.
   input wire logic [15:0] IO_ADDR,
   input wire logic        IO_WR,
   input wire logic        IO_RD,
   input wire logic [7:0]  IO_WDATA,
   input wire logic [7:0]  IO_RDATA,
   // Display side.
   input wire logic [7:0]  PIX_ATTR,
   input wire logic [7:0]  COLOR_OUT,
   input wire logic        PIXEL_WIDTH_8BIT,
   input wire logic        MONO_EMULATION,
   input wire logic        GRAPHICS_MODE,
   input wire logic        LINE_GFX_ENABLE,
   input wire logic        BLINK_ENABLE,
   input wire logic        PALETTE_SOURCE_VIDEO
);
   logic       sel_r;
   logic [4:0] idx_r;
   logic       stat;
   logic       wr_i;
   logic       wr_d;
   logic       rd_d;
   assign stat = IO_RD && (IO_ADDR == 16'h03BA || IO_ADDR == 16'h03DA);
   assign wr_i = IO_WR && IO_ADDR == 16'h03C0 && !sel_r;
   assign wr_d = IO_WR && IO_ADDR == 16'h03C0 && sel_r;
   assign rd_d = IO_RD && IO_ADDR == 16'h03C1;
   // Shadow of the index/data selector, so reads can be tied to the index.
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) sel_r <= 1'b0;
      else if (stat) sel_r <= 1'b0;
      else if (IO_WR && IO_ADDR == 16'h03C0) sel_r <= !sel_r;
   end
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) idx_r <= 5'h00;
      else if (wr_i) idx_r <= IO_WDATA[4:0];
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   property p_rd_hold; !rd_d |=> $stable(IO_RDATA); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_rd_none; rd_d && idx_r > 5'h14 |=> IO_RDATA == 8'h00; endproperty
   a_rd_none: assert property (p_rd_none) else $error("unmapped read not 0");
   property p_rd_mode; rd_d && idx_r == 5'h10 |=> !IO_RDATA[4]; endproperty
   a_rd_mode: assert property (p_rd_mode) else $error("mode bit 4 set");
   property p_rd_pal; rd_d && idx_r < 5'h10 |=> IO_RDATA[7:6] == 2'b00; endproperty
   a_rd_pal: assert property (p_rd_pal) else $error("palette top bits set");
   property p_src; logic b; (wr_i, b = IO_WDATA[5]) |-> ##2 PALETTE_SOURCE_VIDEO == b; endproperty
   a_src: assert property (p_src) else $error("source flag wrong");
   property p_flags;
      logic [7:0] w;
      (wr_d && idx_r == 5'h10, w = IO_WDATA) |-> ##2 {PIXEL_WIDTH_8BIT, BLINK_ENABLE,
         LINE_GFX_ENABLE, MONO_EMULATION, GRAPHICS_MODE} == {w[6], w[3:0]};
   endproperty
   a_flags: assert property (p_flags) else $error("mode flags wrong");
   property p_pix8; PIXEL_WIDTH_8BIT ##1 PIXEL_WIDTH_8BIT |-> COLOR_OUT == $past(PIX_ATTR);
   endproperty
   a_pix8: assert property (p_pix8) else $error("8-bit colour wrong");
   property p_cfg;
      !IO_WR ##1 !IO_WR |=> $stable({PIXEL_WIDTH_8BIT, BLINK_ENABLE, LINE_GFX_ENABLE,
         MONO_EMULATION, GRAPHICS_MODE, PALETTE_SOURCE_VIDEO});
   endproperty
   a_cfg: assert property (p_cfg) else $error("flags moved without write");
   c_stat: cover property (stat);
   c_mode: cover property (wr_d && idx_r == 5'h10);
   c_pix8: cover property (PIXEL_WIDTH_8BIT ##1 PIXEL_WIDTH_8BIT);
endmodule : apc_attr_ctrl_checker
bind apc_attr_ctrl apc_attr_ctrl_checker u_chk (.CLK, .SYS_RST, .IO_ADDR, .IO_WR, .IO_RD,
   .IO_WDATA, .IO_RDATA, .PIX_ATTR, .COLOR_OUT, .PIXEL_WIDTH_8BIT, .MONO_EMULATION,
   .GRAPHICS_MODE, .LINE_GFX_ENABLE, .BLINK_ENABLE, .PALETTE_SOURCE_VIDEO);

// >>> apc_host_model.sv
// Host processor model issuing I/O port reads and writes.
`timescale 1ns/1ns
module apc_host_model (
   // Clock and read data.
   input  wire logic        CLK,
   input  wire logic [7:0]  IO_RDATA,
   // I/O request.
   output logic      [15:0] IO_ADDR,
   output logic             IO_WR,
   output logic             IO_RD,
   output logic      [7:0]  IO_WDATA
);
   initial {IO_ADDR, IO_WR, IO_RD, IO_WDATA} = '0;
   // One write to the attribute port; address and data are scrambled once released.
   task automatic wr(input logic [7:0] v);
      @(negedge CLK);
      IO_ADDR  = 16'h03C0;
      IO_WDATA = v;
      IO_WR    = 1'b1;
      @(negedge CLK);
      IO_WR    = 1'b0;
      IO_WDATA = ~v;
      IO_ADDR  = ~IO_ADDR;
   endtask : wr
   // One read; the data is taken after the registered answer has loaded.
   task automatic rd(input logic [15:0] a, output logic [7:0] v);
      @(negedge CLK);
      IO_ADDR = a;
      IO_RD   = 1'b1;
      @(negedge CLK);
      IO_RD   = 1'b0;
      IO_ADDR = ~a;
      v       = IO_RDATA;
   endtask : rd
endmodule : apc_host_model

// >>> apc_attr_ctrl_tb.sv
// Self-checking testbench for the attribute palette controller.
`timescale 1ns/1ns
module apc_attr_ctrl_tb;
   logic        clk, sys_rst, io_wr, io_rd, lcm, vsync, pw8, mono, gfx, lgfx, blink, src;
   logic [15:0] io_addr;
   logic [7:0]  io_wdata, io_rdata, pix_attr, color_out, d;
   logic        blink_ph;
   logic [7:0]  ovs;
   logic [3:0]  pan_out, plane_en;
   int          errors = 0;
   int          total_checks = 0;
   apc_attr_ctrl DUT (
      .CLK(clk), .SYS_RST(sys_rst), .IO_ADDR(io_addr), .IO_WR(io_wr), .IO_RD(io_rd),
      .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .PIX_ATTR(pix_attr), .PIX_BLINK_PHASE(blink_ph),
      .LINE_CMP_MATCH(lcm), .VSYNC(vsync), .COLOR_OUT(color_out), .PAN_OUT(pan_out),
      .PLANE_ENABLE(plane_en), .OVERSCAN_COLOR(ovs),
      .PIXEL_WIDTH_8BIT(pw8), .MONO_EMULATION(mono),
      .GRAPHICS_MODE(gfx), .LINE_GFX_ENABLE(lgfx), .BLINK_ENABLE(blink),
      .PALETTE_SOURCE_VIDEO(src));
   apc_host_model host (.CLK(clk), .IO_RDATA(io_rdata), .IO_ADDR(io_addr), .IO_WR(io_wr),
                        .IO_RD(io_rd), .IO_WDATA(io_wdata));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic test_done;
      if (errors == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   // A status read first, so each access starts from the index register.
   task automatic reg_wr(input logic [7:0] i, input logic [7:0] v);
      host.rd(16'h03DA, d);
      host.wr(i);
      host.wr(v);
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] i, input logic [7:0] exp);
      host.rd(16'h03DA, d);
      host.wr(i);
      host.rd(16'h03C1, d);
      chk(d, exp);
   endtask : reg_rd
   initial begin
      repeat (50000) @(posedge clk);
      errors++;
      test_done();
   end
   initial begin
      {sys_rst, lcm, vsync, blink_ph, pix_attr} = {1'b1, 11'h000};
      repeat (8) @(posedge clk);
      @(negedge clk) sys_rst = 1'b0;
      host.rd(16'h03DA, d);
      host.wr(8'h10);
      host.rd(16'h03C1, d);
      host.wr(8'hFF);
      reg_rd(8'h10, 8'hEF);
      chk({3'b000, pw8, blink, lgfx, mono, gfx}, 8'h1F);
      pix_attr = 8'hA5;
      repeat (2) @(negedge clk);
      chk(color_out, 8'hA5);
      host.wr(8'h14);
      host.rd(16'h03BA, d);
      host.wr(8'h03);
      host.wr(8'hFF);
      reg_rd(8'h03, 8'h3F);
      vsync = 1'b1;
      for (int i = 0; i < 16; i++) reg_wr(8'(i), 8'(8'hC0 + i * 3));
      vsync = 1'b0;
      for (int i = 0; i < 16; i++) reg_rd(8'(i), 8'(i * 3));
      reg_wr(8'h25, 8'h00);
      chk({7'h00, src}, 8'h01);
      reg_rd(8'h05, 8'h0F);
      reg_wr(8'h15, 8'h77);
      reg_rd(8'h15, 8'h00);
      reg_wr(8'h12, 8'h0F);
      reg_wr(8'h14, 8'h0E);
      reg_wr(8'h10, 8'h00);
      reg_wr(8'h33, 8'h07);
      pix_attr = 8'h03;
      repeat (3) @(negedge clk);
      chk(color_out, 8'hC9);
      reg_wr(8'h30, 8'hA0);
      repeat (3) @(negedge clk);
      chk(color_out, 8'hE9);
      chk({4'h0, pan_out}, 8'h07);
      lcm = 1'b1;
      repeat (2) @(negedge clk);
      lcm = 1'b0;
      repeat (8) @(negedge clk);
      chk({4'h0, pan_out}, 8'h00);
      vsync = 1'b1;
      repeat (6) @(negedge clk);
      vsync = 1'b0;
      chk({4'h0, pan_out}, 8'h07);
      reg_wr(8'h30, 8'h80);
      lcm = 1'b1;
      repeat (2) @(negedge clk);
      lcm = 1'b0;
      repeat (8) @(negedge clk);
      chk({4'h0, pan_out}, 8'h07);
      reg_wr(8'h31, 8'h5A);
      reg_wr(8'h30, 8'h08);
      {pix_attr, blink_ph} = {8'hA5, 1'b1};
      repeat (3) @(negedge clk);
      chk(color_out, 8'hC6);
      chk({7'h00, blink}, 8'h01);
      chk(ovs, 8'h5A);
      chk({4'h0, plane_en}, 8'h0F);
      blink_ph = 1'b0;
      repeat (2) @(negedge clk);
      chk(color_out, 8'hCF);
      sys_rst = 1'b1;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      reg_rd(8'h10, 8'h00);
      reg_rd(8'h03, 8'h00);
      chk(color_out, 8'h00);
      test_done();
   end
endmodule : apc_attr_ctrl_tb
